// ===== rtl/nvmcfg_pkg.sv
// package: register map, field layout, reset values and types of the nvm config bank
// Behaviour
// R1: hold clear: sense amps off after read+idle
// R2: hold set: sense amps stay on
// R3: persist clear: arrays reset on system or power-on
// R4: persist set: arrays reset on power-on only
// R5: writable nvm_config register at 0x4003800C
// R6: writable fabric_remap_config register at 0x40038014
// R7: permissions read-only, loaded from programming bits
// R8: read-only shadow_status register at 0x40038148
// R9: read-only per-array busy status at 0x40038158
// R10: any matrix master may read arrays directly
// R11: controller writes unreserved pages, reads reserved only
// R12: busy bits: bit1 second, bit0 first array
// R13: remap bit0 enables, bits 18:1 pick base
// R14: shadow bit0 tells code shadowing configured
package nvmcfg_pkg;

   // byte addresses of the bank on the system map
   localparam logic [31:0] NVMCFG_ADDR_CONFIG   = 32'h4003800C;
   localparam logic [31:0] NVMCFG_ADDR_REMAP    = 32'h40038014;
   localparam logic [31:0] NVMCFG_ADDR_PROTECT  = 32'h40038144;
   localparam logic [31:0] NVMCFG_ADDR_SHADOW   = 32'h40038148;
   localparam logic [31:0] NVMCFG_ADDR_BUSY     = 32'h40038158;

   // field positions
   localparam int NVMCFG_SENSE_BIT      = 16;
   localparam int NVMCFG_PERSIST_BIT    = 15;
   localparam int NVMCFG_REMAP_EN_BIT   = 0;
   localparam int NVMCFG_REMAP_BASE_LSB = 1;
   localparam int NVMCFG_REMAP_BASE_MSB = 18;
   localparam int NVMCFG_SHADOW_BIT     = 0;

   // field masks: only documented fields stick, on writes and on the programmed permissions
   localparam logic [31:0] NVMCFG_CONFIG_MASK  = 32'h00018000;
   localparam logic [31:0] NVMCFG_REMAP_MASK   = 32'h0007FFFF;
   localparam logic [31:0] NVMCFG_PROTECT_MASK = 32'h0000EEEE;

   // reset values
   localparam logic [31:0] NVMCFG_CONFIG_RST  = 32'h00000000;
   localparam logic [31:0] NVMCFG_REMAP_RST   = 32'h00000000;
   localparam logic [31:0] NVMCFG_PROTECT_RST = 32'h0000EEEE;

   // default answer on an unmapped read
   localparam logic [31:0] NVMCFG_UNMAPPED_RD = 32'h00000000;

   // control outputs of the bank towards the arrays and the remap logic
   typedef struct packed {
      logic        sense_amp_hold_on;            // sense amps stay powered
      logic        keep_arrays_across_sys_reset; // system reset spares arrays
      logic        fabric_remap_on;              // remap enabled
      logic [17:0] fabric_remap_base;            // remapped segment base
   } nvmcfg_ctrl_t;

   // bus access decoded to one register
   typedef enum logic [5:0] {
      NVMCFG_SEL_NONE    = 6'h01,
      NVMCFG_SEL_CONFIG  = 6'h02,
      NVMCFG_SEL_REMAP   = 6'h04,
      NVMCFG_SEL_PROTECT = 6'h08,
      NVMCFG_SEL_SHADOW  = 6'h10,
      NVMCFG_SEL_BUSY    = 6'h20
   } nvmcfg_sel_t;

   // access phase of the slave
   typedef enum logic [1:0] {
      NVMCFG_ST_IDLE = 2'h1,
      NVMCFG_ST_DONE = 2'h2
   } nvmcfg_state_t;

endpackage

// ===== rtl/nvmcfg_sense_ctrl.sv
// sense amplifier power control for both arrays
`timescale 1ns/1ps
`default_nettype none
module nvmcfg_sense_ctrl #(
   parameter int NUM_ARRAYS = 2
)(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  arst_n_i,
   // control
   input  wire logic                  hold_on_i,
   // array activity
   input  wire logic [NUM_ARRAYS-1:0] read_active_i,
   // sense amp enables
   output logic      [NUM_ARRAYS-1:0] sense_amp_en_o
);

   // refuse a width the amp logic cannot serve, at elaboration
   if (NUM_ARRAYS < 1)
   begin : g_bad_width
      $error("need at least one array");
   end

   logic [NUM_ARRAYS-1:0] was_read_q; // previous cycle was a read
   logic [NUM_ARRAYS-1:0] was_read_d;

   assign was_read_d = read_active_i;

   // remember last read; masked by the current read, so with hold clear the amp is on only while read_active_i is high
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         was_read_q <= '0;
      else
         was_read_q <= was_read_d;
   end

   genvar g;
   generate
      for (g = 0; g < NUM_ARRAYS; g++)
      begin : g_amp
         // off after a read followed by idle; trades speed for power
         assign sense_amp_en_o[g] = hold_on_i ? 1'b1 :         // [R2]
                                    (read_active_i[g] | was_read_q[g]) & read_active_i[g]; // [R1]
      end
   endgenerate

endmodule // nvmcfg_sense_ctrl
`default_nettype wire

// ===== rtl/nvmcfg_reset_ctrl.sv
// array reset selection between system and power-on reset
`timescale 1ns/1ps
`default_nettype none
module nvmcfg_reset_ctrl (
   // reset sources
   input  wire logic power_on_reset_low_i,
   input  wire logic sys_reset_low_i,
   // control
   input  wire logic persist_i,
   // reset to the arrays
   output logic      array_reset_low_o
);

   // persist keeps array contents/state through a system reset
   assign array_reset_low_o = persist_i ? power_on_reset_low_i                       // [R4]
                                        : (power_on_reset_low_i & sys_reset_low_i); // [R3]

endmodule // nvmcfg_reset_ctrl
`default_nettype wire

// ===== rtl/nvmcfg_regs.sv
// nvm system configuration register bank with avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
module nvmcfg_regs #(
   parameter int NUM_ARRAYS = 2
)(
   // clock and reset (reset is the system reset)
   input  wire logic                       clk_i,
   input  wire logic                       arst_n_i,
   // power-on reset level from the supply monitor
   input  wire logic                       power_on_reset_low_i,
   // avalon-mm slave
   input  wire logic [31:0]                avs_address_i,
   input  wire logic                       avs_read_i,
   input  wire logic                       avs_write_i,
   input  wire logic [31:0]                avs_writedata_i,
   input  wire logic [3:0]                 avs_byteenable_i,
   output logic      [31:0]                avs_readdata_o,
   output logic                            avs_waitrequest_o,
   output logic      [1:0]                 avs_response_o,
   // programming-time configuration bits
   input  wire logic [31:0]                prog_permissions_i,
   input  wire logic                       prog_shadow_en_i,
   // array status
   input  wire logic [NUM_ARRAYS-1:0]      per_array_busy_i,
   input  wire logic [NUM_ARRAYS-1:0]      read_active_i,
   // controls to the arrays
   output nvmcfg_pkg::nvmcfg_ctrl_t        ctrl_o,
   output logic      [NUM_ARRAYS-1:0]      sense_amp_en_o,
   output logic                            array_reset_low_o,
   output logic      [31:0]                region_access_permissions_o
);

   // refuse an array count the busy layout cannot serve, at elaboration
   if (NUM_ARRAYS != 2)
   begin : g_bad_arrays
      $error("busy layout serves exactly two arrays");
   end

   // registers
   logic [31:0] config_q;      // nvm_config
   logic [31:0] config_d;
   logic [31:0] remap_q;       // fabric_remap_config
   logic [31:0] remap_d;
   logic [31:0] protect_q;     // region_access_permissions
   logic [31:0] protect_d;
   logic        shadow_q;      // shadow_status bit
   logic        shadow_d;
   logic [1:0]  busy_q;        // array_busy_status
   logic [1:0]  busy_d;
   logic        loaded_q;      // programming bits captured
   logic        loaded_d;
   logic [31:0] rdata_q;       // read data
   logic [31:0] rdata_d;
   logic [1:0]  resp_q;        // response code
   logic [1:0]  resp_d;
   logic        persist_keep_q; // persist bit as it stood before system reset
   logic        persist_keep_d;
   nvmcfg_pkg::nvmcfg_state_t state_q;
   nvmcfg_pkg::nvmcfg_state_t state_d;

   // decode one address to a register select
   function automatic nvmcfg_pkg::nvmcfg_sel_t decode(input logic [31:0] a);
      case (a)
         nvmcfg_pkg::NVMCFG_ADDR_CONFIG:  decode = nvmcfg_pkg::NVMCFG_SEL_CONFIG;
         nvmcfg_pkg::NVMCFG_ADDR_REMAP:   decode = nvmcfg_pkg::NVMCFG_SEL_REMAP;
         nvmcfg_pkg::NVMCFG_ADDR_PROTECT: decode = nvmcfg_pkg::NVMCFG_SEL_PROTECT;
         nvmcfg_pkg::NVMCFG_ADDR_SHADOW:  decode = nvmcfg_pkg::NVMCFG_SEL_SHADOW;
         nvmcfg_pkg::NVMCFG_ADDR_BUSY:    decode = nvmcfg_pkg::NVMCFG_SEL_BUSY;
         default:                         decode = nvmcfg_pkg::NVMCFG_SEL_NONE;
      endcase
   endfunction

   // merge write data into a register under byte enables and a field mask
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] mask);
      logic [31:0] lane;
      lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
      merge = (old & ~lane) | (wd & lane);
   endfunction

   // decode and strobes
   nvmcfg_pkg::nvmcfg_sel_t sel;
   wire         req      = avs_read_i | avs_write_i;
   wire         in_idle  = (state_q == nvmcfg_pkg::NVMCFG_ST_IDLE);
   wire         take     = req & in_idle;
   wire         wr_take  = take & avs_write_i;
   wire         wr_cfg   = wr_take & (sel == nvmcfg_pkg::NVMCFG_SEL_CONFIG);   // [R5]
   wire         wr_remap = wr_take & (sel == nvmcfg_pkg::NVMCFG_SEL_REMAP);    // [R6]
   wire         unmapped = (sel == nvmcfg_pkg::NVMCFG_SEL_NONE);
   logic [31:0] rd_mux;

   assign sel = decode(avs_address_i);

   // read selection; reserved bits read zero
   always_comb
   begin
      case (sel)
         nvmcfg_pkg::NVMCFG_SEL_CONFIG:  rd_mux = config_q;
         nvmcfg_pkg::NVMCFG_SEL_REMAP:   rd_mux = remap_q;
         nvmcfg_pkg::NVMCFG_SEL_PROTECT: rd_mux = protect_q;                    // [R7]
         nvmcfg_pkg::NVMCFG_SEL_SHADOW:  rd_mux = {31'h00000000, shadow_q};     // [R8] [R14]
         nvmcfg_pkg::NVMCFG_SEL_BUSY:    rd_mux = {30'h00000000, busy_q};       // [R9] [R12]
         default:                        rd_mux = nvmcfg_pkg::NVMCFG_UNMAPPED_RD;
      endcase
   end

   // next values; read-only registers ignore writes without error
   assign config_d  = wr_cfg ? merge(config_q, avs_writedata_i, avs_byteenable_i,
                                     nvmcfg_pkg::NVMCFG_CONFIG_MASK) : config_q;
   assign remap_d   = wr_remap ? merge(remap_q, avs_writedata_i, avs_byteenable_i,
                                       nvmcfg_pkg::NVMCFG_REMAP_MASK) : remap_q;
   // permissions come only from the programmed bits, captured once after reset
   assign protect_d = loaded_q ? protect_q
                               : (prog_permissions_i & nvmcfg_pkg::NVMCFG_PROTECT_MASK); // [R7]
   assign shadow_d  = loaded_q ? shadow_q : prog_shadow_en_i;                            // [R14]
   assign loaded_d  = 1'b1;
   // busy sampled every cycle; bit1 second array, bit0 first
   assign busy_d    = {per_array_busy_i[1], per_array_busy_i[0]};                        // [R12]
   assign rdata_d   = (take & avs_read_i) ? rd_mux : rdata_q;
   assign resp_d    = take ? (unmapped ? 2'b11 : 2'b00) : resp_q;
   assign state_d   = take ? nvmcfg_pkg::NVMCFG_ST_DONE : nvmcfg_pkg::NVMCFG_ST_IDLE;

   // register storage, system reset domain
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         config_q  <= nvmcfg_pkg::NVMCFG_CONFIG_RST;
         remap_q   <= nvmcfg_pkg::NVMCFG_REMAP_RST;
         protect_q <= nvmcfg_pkg::NVMCFG_PROTECT_RST;
         shadow_q  <= 1'b0;
         loaded_q  <= 1'b0;
      end
      else
      begin
         config_q  <= config_d;
         remap_q   <= remap_d;
         protect_q <= protect_d;
         shadow_q  <= shadow_d;
         loaded_q  <= loaded_d;
      end
   end

   // bus side state and status sampling
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         busy_q  <= 2'h0;
         rdata_q <= 32'h00000000;
         resp_q  <= 2'h0;
         state_q <= nvmcfg_pkg::NVMCFG_ST_IDLE;
      end
      else
      begin
         busy_q  <= busy_d;
         rdata_q <= rdata_d;
         resp_q  <= resp_d;
         state_q <= state_d;
      end
   end

   // persist copy outlives the register's own reset; power-on clears it, and the first clock after system reset reloads the cleared bit;
   // frozen while system reset is low, lags a write by one clock
   assign persist_keep_d = arst_n_i ? config_q[nvmcfg_pkg::NVMCFG_PERSIST_BIT] : persist_keep_q; // [R4]

   // persist copy storage, power-on reset domain
   always_ff @(posedge clk_i or negedge power_on_reset_low_i)
   begin
      if (!power_on_reset_low_i)
         persist_keep_q <= 1'b0;
      else
         persist_keep_q <= persist_keep_d;
   end

   // one wait cycle per access: answer lands the cycle after the take
   assign avs_waitrequest_o = req & in_idle;
   assign avs_readdata_o    = rdata_q;
   assign avs_response_o    = resp_q;

   // control fields out to the arrays and the fabric remap decoder
   assign ctrl_o.sense_amp_hold_on            = config_q[nvmcfg_pkg::NVMCFG_SENSE_BIT];
   assign ctrl_o.keep_arrays_across_sys_reset = config_q[nvmcfg_pkg::NVMCFG_PERSIST_BIT];
   assign ctrl_o.fabric_remap_on              = remap_q[nvmcfg_pkg::NVMCFG_REMAP_EN_BIT];  // [R13]
   assign ctrl_o.fabric_remap_base            =
      remap_q[nvmcfg_pkg::NVMCFG_REMAP_BASE_MSB:nvmcfg_pkg::NVMCFG_REMAP_BASE_LSB];         // [R13]
   // permissions feed the array access checks of every matrix master
   assign region_access_permissions_o = protect_q;                                          // [R10] [R11]

   // sense amp power
   nvmcfg_sense_ctrl #(
      .NUM_ARRAYS (NUM_ARRAYS)
   ) u_sense (
      .clk_i          (clk_i),
      .arst_n_i       (arst_n_i),
      .hold_on_i      (config_q[nvmcfg_pkg::NVMCFG_SENSE_BIT]),    // [R1] [R2]
      .read_active_i  (read_active_i),
      .sense_amp_en_o (sense_amp_en_o)
   );

   // array reset source selection
   nvmcfg_reset_ctrl u_rst (
      .power_on_reset_low_i (power_on_reset_low_i),
      .sys_reset_low_i      (arst_n_i),
      .persist_i            (persist_keep_q), // [R3] [R4]
      .array_reset_low_o    (array_reset_low_o)
   );

endmodule // nvmcfg_regs
`default_nettype wire

// ===== test/nvmcfg_monitor.sv
// checker for the nvm config bank ports
`timescale 1ns/1ps
`default_nettype none
module nvmcfg_monitor #(
   parameter int NUM_ARRAYS = 2
)(
   // clock and resets
   input wire logic                     clk_i,
   input wire logic                     arst_n_i,
   input wire logic                     power_on_reset_low_i,
   // avalon-mm slave side
   input wire logic [31:0]              avs_address_i,
   input wire logic                     avs_read_i,
   input wire logic                     avs_write_i,
   input wire logic [31:0]              avs_writedata_i,
   input wire logic [3:0]               avs_byteenable_i,
   input wire logic [31:0]              avs_readdata_o,
   input wire logic                     avs_waitrequest_o,
   // array side
   input wire logic [NUM_ARRAYS-1:0]    per_array_busy_i,
   input wire logic [NUM_ARRAYS-1:0]    read_active_i,
   input wire nvmcfg_pkg::nvmcfg_ctrl_t ctrl_o,
   input wire logic [NUM_ARRAYS-1:0]    sense_amp_en_o,
   input wire logic                     array_reset_low_o,
   input wire logic [31:0]              region_access_permissions_o
);
   // one domain: clock and system reset for all but persist_hold_a
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // a taken request ends after exactly one wait
   one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest held past one cycle");
   // controls only move on a write
   ctrl_stable_a: assert property (!avs_write_i |=> $stable(ctrl_o))
      else $error("controls changed without a write");
   // sense hold bit lands from lane 2
   hold_write_a: assert property (avs_write_i && avs_waitrequest_o && avs_address_i == nvmcfg_pkg::NVMCFG_ADDR_CONFIG
      && avs_byteenable_i[2] |=> ctrl_o.sense_amp_hold_on == $past(avs_writedata_i[16]))
      else $error("sense hold field not stored");
   // whole remap field lands on a full write
   remap_write_a: assert property (avs_write_i && avs_waitrequest_o && avs_address_i == nvmcfg_pkg::NVMCFG_ADDR_REMAP
      && avs_byteenable_i == 4'hF |=> {ctrl_o.fabric_remap_base, ctrl_o.fabric_remap_on} == $past(avs_writedata_i[18:0]))
      else $error("remap field not stored");
   // hold set keeps every sense amp on
   sense_hold_a: assert property (ctrl_o.sense_amp_hold_on |-> &sense_amp_en_o)
      else $error("sense amp off while hold set");
   // idle two cycles with hold clear means off
   sense_off_a: assert property (!ctrl_o.sense_amp_hold_on |->
      (sense_amp_en_o & ~read_active_i & ~$past(read_active_i)) == '0)
      else $error("sense amp on after idle");
   // out of system reset the arrays follow power-on reset only
   reset_sel_a: assert property (array_reset_low_o == power_on_reset_low_i)
      else $error("array reset does not follow power-on reset");
   // busy read returns the per-array levels
   busy_read_a: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == nvmcfg_pkg::NVMCFG_ADDR_BUSY
      |=> avs_readdata_o == 32'($past(per_array_busy_i, 2)))
      else $error("busy read mismatch");
   // permission read mirrors the permission output
   perm_read_a: assert property (avs_read_i && avs_waitrequest_o && avs_address_i == nvmcfg_pkg::NVMCFG_ADDR_PROTECT
      |=> avs_readdata_o == region_access_permissions_o)
      else $error("permission read mismatch");
   // system reset spares the arrays only when persist stood set before it
   persist_hold_a: assert property (disable iff (1'b0) $past(arst_n_i) && !arst_n_i && power_on_reset_low_i
      |-> array_reset_low_o == $past(ctrl_o.keep_arrays_across_sys_reset))
      else $error("array reset ignores persist setting");
endmodule // nvmcfg_monitor
bind nvmcfg_regs nvmcfg_monitor #(.NUM_ARRAYS(NUM_ARRAYS)) u_mon (.clk_i, .arst_n_i, .power_on_reset_low_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
   .avs_waitrequest_o, .per_array_busy_i, .read_active_i, .ctrl_o, .sense_amp_en_o, .array_reset_low_o,
   .region_access_permissions_o);
`default_nettype wire

// ===== test/nvmcfg_tb.sv
// self-checking bench for the nvm config bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // design inputs, all set at time zero
   logic        clk_i = 0, arst_n_i = 0, por_n = 1, rd_i = 0, wr_i = 0, shadow = 1;
   logic [31:0] addr = 0, wdata = 0, perm = 0, d;
   logic [3:0]  be = 4'hF;
   logic [1:0]  busy = 0, ract = 0;
   // design outputs
   logic [31:0] rdata, perm_o;
   logic        waitreq, arr_rst_n;
   logic [1:0]  resp, sense;
   nvmcfg_pkg::nvmcfg_ctrl_t ctrl;
   // expected read answers, {response, data}
   logic [33:0] q[$];
   logic [33:0] x;
   integer      seed = 32'hEDD30D71;
   int          num_errors = 0, n_compared = 0, i;
   nvmcfg_regs dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .power_on_reset_low_i(por_n), .avs_address_i(addr),
      .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .avs_response_o(resp),
      .prog_permissions_i(perm), .prog_shadow_en_i(shadow), .per_array_busy_i(busy), .read_active_i(ract),
      .ctrl_o(ctrl), .sense_amp_en_o(sense), .array_reset_low_o(arr_rst_n), .region_access_permissions_o(perm_o));
   // 10 mhz clock
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end
   // compare and count
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // one bus cycle, held until waitrequest is seen low at a rising edge
   task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] dv, input logic [3:0] b);
      @(posedge clk_i);
      addr <= a;
      wdata <= dv;
      be <= b;
      if (w) wr_i <= 1'b1; else rd_i <= 1'b1;
      // waitrequest looked at on rising edges only; the watchdog ends a hung wait
      do
      begin
         @(posedge clk_i);
      end
      while (waitreq);
      rd_i <= 1'b0;
      wr_i <= 1'b0;
   endtask
   // read with a noted answer
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
      q.push_back({r, e});
      acc(1'b0, a, 32'h0, 4'hF);
   endtask
   // verdict and end of run
   task automatic final_report;
      $display("counts: compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // read answers are taken at the completing rising edge
   always @(posedge clk_i)
   begin
      if (rd_i && !waitreq)
      begin
         x = q.pop_front();
         chk("readdata", rdata, x[31:0]);
         chk("response", 32'(resp), 32'(x[33:32]));
      end
   end
   // watchdog: run is about 100 cycles
   initial
   begin
      repeat (3000) @(posedge clk_i);
      num_errors++;
      final_report;
   end
   // main sequence
   initial
   begin
      perm <= $random(seed);
      repeat (12) @(posedge clk_i);
      chk("sys reset to arrays", 32'(arr_rst_n), 32'h0);
      arst_n_i <= 1'b1;
      rd(nvmcfg_pkg::NVMCFG_ADDR_CONFIG, nvmcfg_pkg::NVMCFG_CONFIG_RST);
      rd(nvmcfg_pkg::NVMCFG_ADDR_PROTECT, perm & nvmcfg_pkg::NVMCFG_PROTECT_MASK);
      rd(nvmcfg_pkg::NVMCFG_ADDR_SHADOW, 32'h1);
      acc(1'b1, nvmcfg_pkg::NVMCFG_ADDR_CONFIG, 32'hFFFFFFFF, 4'hF);
      rd(nvmcfg_pkg::NVMCFG_ADDR_CONFIG, 32'h00018000);
      // lane 1 only clears persist, hold survives
      acc(1'b1, nvmcfg_pkg::NVMCFG_ADDR_CONFIG, 32'h0, 4'h2);
      rd(nvmcfg_pkg::NVMCFG_ADDR_CONFIG, 32'h00010000);
      ract <= 2'($random(seed));
      @(posedge clk_i);
      chk("sense held", 32'(sense), 32'h3);
      acc(1'b1, nvmcfg_pkg::NVMCFG_ADDR_CONFIG, 32'h00008000, 4'hF);
      ract <= 2'h0;
      repeat (3) @(posedge clk_i);
      chk("sense idle", 32'(sense), 32'h0);
      por_n <= 1'b0;
      @(posedge clk_i);
      chk("por to arrays", 32'(arr_rst_n), 32'h0);
      por_n <= 1'b1;
      @(posedge clk_i);
      chk("arrays kept", 32'(arr_rst_n), 32'h1);
      // mid-run system reset with persist set spares the arrays
      arst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk("arrays kept over sys reset", 32'(arr_rst_n), 32'h1);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      // persist now back at its reset value: system reset reaches the arrays
      arst_n_i <= 1'b0;
      @(posedge clk_i);
      chk("arrays reset by sys reset", 32'(arr_rst_n), 32'h0);
      arst_n_i <= 1'b1;
      rd(nvmcfg_pkg::NVMCFG_ADDR_CONFIG, nvmcfg_pkg::NVMCFG_CONFIG_RST);
      for (i = 0; i < 4; i++)
      begin
         d = $random(seed);
         acc(1'b1, nvmcfg_pkg::NVMCFG_ADDR_REMAP, d, 4'hF);
         rd(nvmcfg_pkg::NVMCFG_ADDR_REMAP, d & nvmcfg_pkg::NVMCFG_REMAP_MASK);
         chk("remap base", 32'(ctrl.fabric_remap_base), 32'(d[18:1]));
         busy <= 2'(i);
         rd(nvmcfg_pkg::NVMCFG_ADDR_BUSY, 32'(i));
      end
      // read-only places ignore writes
      acc(1'b1, nvmcfg_pkg::NVMCFG_ADDR_PROTECT, 32'h0, 4'hF);
      acc(1'b1, nvmcfg_pkg::NVMCFG_ADDR_SHADOW, 32'h0, 4'hF);
      rd(nvmcfg_pkg::NVMCFG_ADDR_PROTECT, perm & nvmcfg_pkg::NVMCFG_PROTECT_MASK);
      rd(nvmcfg_pkg::NVMCFG_ADDR_SHADOW, 32'h1);
      rd(32'h40038010, nvmcfg_pkg::NVMCFG_UNMAPPED_RD, 2'h3);
      repeat (2) @(posedge clk_i);
      final_report;
   end
endmodule // testbench
`default_nettype wire
